/* File: rtl/ccsd_pkg.sv */
/*
 Package for the processor clock switch and divider: register offsets, field
 positions, reset values, source codes and wake-up timing counts.
 Assumes a 20 MHz system clock that also stands in for the oscillator clock.
*/
package ccsd_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;

  // Register byte addresses on the Wishbone slave
  localparam logic [3:0] OFS_CLKSRC = 4'h0;
  localparam logic [3:0] OFS_DIV    = 4'h4;
  localparam logic [3:0] OFS_AUX1   = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;

  // Clock source control register fields
  localparam int unsigned SRC_LSB    = 0;
  localparam int unsigned SRC_MSB    = 2;
  localparam int unsigned SWDONE_BIT = 7;
  // Auxiliary register one: low-power clocking bit
  localparam int unsigned LOWPWR_BIT = 7;
  // Status register: processor clock running
  localparam int unsigned RUN_BIT    = 0;

  typedef enum logic [2:0] {
    SRC_WDOSC  = 3'h0,
    SRC_RCOSC  = 3'h1,
    SRC_XTLOW  = 3'h2,
    SRC_XTMED  = 3'h3,
    SRC_XTHIGH = 3'h4,
    SRC_EXTCLK = 3'h5
  } ccsd_src_t;

  localparam logic [2:0] SRC_RESET = 3'h1;
  localparam logic [7:0] DIV_RESET = 8'h00;

  // Wake-up delays
  localparam int unsigned XTAL_OSC_CYC = 1024;
  localparam int unsigned XTAL_EXTRA_US = 60;
  localparam int unsigned RC_MIN_US     = 200;
  localparam int unsigned SHORT_OSC_CYC = 32;
  // Least times round up to whole cycles
  localparam int unsigned XTAL_EXTRA_CYC = (XTAL_EXTRA_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int unsigned RC_CYC         = (RC_MIN_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam logic [12:0] XTAL_WAKE = 13'(XTAL_OSC_CYC + XTAL_EXTRA_CYC);
  localparam logic [12:0] RC_WAKE   = 13'(RC_CYC);
  localparam logic [12:0] SHORT_WAKE = 13'(SHORT_OSC_CYC);

endpackage : ccsd_pkg

/* File: rtl/ccsd_divider.sv */
/*
 Processor clock divider: produces a one-cycle enable every 2*div oscillator
 cycles, or every cycle when div is zero.
 Assumes the enable is gated off by the caller while the clock is held.
*/
`timescale 1ns/1ps
`default_nettype none
module ccsd_divider
  import ccsd_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       run,
  input  wire logic [7:0] div,
  output logic            tick
);

  typedef struct packed {
    logic [8:0] cnt;
    logic       tick;
  } ccsd_div_st_t;

  ccsd_div_st_t st_ff, nxt_st;
  logic [8:0]   lastCnt;

  always_comb begin
    nxt_st  = st_ff;
    lastCnt = {div, 1'b0} - 9'h001;
    nxt_st.tick = 1'b0;
    if (!run) begin
      nxt_st.cnt = 9'h000;
    end else if (div == 8'h00) begin
      nxt_st.tick = 1'b1;
      nxt_st.cnt  = 9'h000;
    end else if (st_ff.cnt >= lastCnt) begin
      // A new ratio applies to the period in progress; a count already past its end ticks at once, without a stall
      nxt_st.tick = 1'b1;
      nxt_st.cnt  = 9'h000;
    end else begin
      nxt_st.cnt = st_ff.cnt + 9'h001;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;

endmodule : ccsd_divider
`default_nettype wire

/* File: rtl/ccsd_top.sv */
/*
 Processor clock switch, wake-up timer and divider with a classic Wishbone
 slave for its registers.
 Assumes the system clock stands in for the oscillator clock; the processor
 clock leaves as a one-cycle enable pulse.
*/
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ccsd_top
  import ccsd_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [3:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatI,
  output logic [31:0]      wbDatO,
  output logic             wbAck,
  output logic             processorClockEn,
  output logic [2:0]       activeSource,
  output logic             lowPowerClocking
);

  typedef struct packed {
    logic [2:0]  src;
    logic [2:0]  pendSrc;
    logic        switchDone;
    logic [7:0]  div;
    logic        lowPower;
    logic        run;
    logic [12:0] wake;
    logic        ack;
    logic [31:0] rdata;
  } ccsd_st_t;

  ccsd_st_t st_ff, nxt_st;
  logic     req;
  logic     divTick;

  // Wake-up length for a source, used on every accepted switch; reset loads RC_WAKE directly
  function automatic logic [12:0] wakeCycles(input logic [2:0] s);
    case (s)
      SRC_XTLOW, SRC_XTMED, SRC_XTHIGH: wakeCycles = XTAL_WAKE;
      SRC_RCOSC:                        wakeCycles = RC_WAKE;
      default:                          wakeCycles = SHORT_WAKE;
    endcase
  endfunction : wakeCycles

  function automatic logic srcLegal(input logic [2:0] s);
    srcLegal = (s <= SRC_EXTCLK);
  endfunction : srcLegal

  assign req = wbCyc && wbStb && !st_ff.ack;

  always_comb begin
    nxt_st     = st_ff;
    nxt_st.ack = req;
    // Wake-up timer holds the processor clock until it runs out
    if (st_ff.wake != 13'h0000) begin
      nxt_st.wake = st_ff.wake - 13'h0001;
      nxt_st.run  = 1'b0;
    end else if (!st_ff.switchDone) begin
      nxt_st.src        = st_ff.pendSrc;
      nxt_st.switchDone = 1'b1;
      nxt_st.run        = 1'b1;
    end
    if (req && wbWe) begin
      case (wbAdr)
        OFS_CLKSRC: begin
          // Writes during a switch are dropped so the timer cannot restart midway
          if (st_ff.switchDone && wbSel[0] && srcLegal(wbDatI[SRC_MSB:SRC_LSB])) begin
            nxt_st.pendSrc    = wbDatI[SRC_MSB:SRC_LSB];
            nxt_st.switchDone = 1'b0;
            nxt_st.run        = 1'b0;
            nxt_st.wake       = wakeCycles(wbDatI[SRC_MSB:SRC_LSB]);
          end
        end
        OFS_DIV: begin
          if (wbSel[0]) begin
            nxt_st.div = wbDatI[7:0];
          end
        end
        OFS_AUX1: begin
          if (wbSel[0]) begin
            nxt_st.lowPower = wbDatI[LOWPWR_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    nxt_st.rdata = 32'h0000_0000;
    if (req && !wbWe) begin
      case (wbAdr)
        OFS_CLKSRC: begin
          nxt_st.rdata[SRC_MSB:SRC_LSB] = st_ff.src;
          nxt_st.rdata[SWDONE_BIT]      = st_ff.switchDone;
        end
        OFS_DIV:    nxt_st.rdata[7:0]         = st_ff.div;
        OFS_AUX1:   nxt_st.rdata[LOWPWR_BIT]  = st_ff.lowPower;
        OFS_STATUS: nxt_st.rdata[RUN_BIT]     = st_ff.run;
        default:    nxt_st.rdata              = 32'h0000_0000;
      endcase
    end
  end

  // Reset starts a wake-up on the reset source; constants only
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_ff            <= '0;
      st_ff.src        <= SRC_RESET;
      st_ff.pendSrc    <= SRC_RESET;
      st_ff.switchDone <= 1'b0;
      st_ff.div        <= DIV_RESET;
      st_ff.lowPower   <= 1'b0;
      st_ff.wake       <= RC_WAKE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ccsd_divider u_div (
    .clock (clock),
    .rstn  (rstn),
    .run   (st_ff.run),
    .div   (st_ff.div),
    .tick  (divTick)
  );

  assign processorClockEn = divTick && st_ff.run;
  assign activeSource     = st_ff.src;
  assign lowPowerClocking = st_ff.lowPower;
  assign wbAck            = st_ff.ack;
  assign wbDatO           = st_ff.rdata;

endmodule : ccsd_top
`default_nettype wire

/* File: tb/ccsd_assertions.sv */
/* Port checker for ccsd_top.
   Assumes it is bound to ccsd_top. */
`timescale 1ns/1ps
`default_nettype none
module ccsd_assertions
  import ccsd_pkg::*;
(
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        wbCyc,
  input wire logic        wbStb,
  input wire logic        wbWe,
  input wire logic [3:0]  wbAdr,
  input wire logic [31:0] wbDatO,
  input wire logic        wbAck,
  input wire logic        processorClockEn,
  input wire logic [2:0]  activeSource,
  input wire logic        lowPowerClocking
);
  logic [12:0] lowCnt_ff;
  // Saturates so a long hold never wraps
  always_ff @(posedge clock or negedge rstn)
    if (!rstn) lowCnt_ff <= '0;
    else lowCnt_ff <= processorClockEn ? '0 : lowCnt_ff + 13'(lowCnt_ff != '1);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  a_ack_follows: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
    else $error("no ack");
  a_ack_single: assert property (wbAck |=> !wbAck) else $error("long ack");
  a_rdata_idle: assert property (!wbAck |-> wbDatO == '0) else $error("stray data");
  a_src_legal: assert property (activeSource <= 3'h5) else $error("bad source");
  a_lowpwr_reset: assert property ($rose(rstn) |-> !lowPowerClocking) else $error("lp set");
  a_short_wake: assert property ($changed(activeSource) && activeSource inside {3'h0, 3'h5}
    |-> lowCnt_ff >= SHORT_WAKE - 2) else $error("short wake");
  a_rc_wake: assert property ($changed(activeSource) && activeSource == 3'h1
    |-> lowCnt_ff >= RC_WAKE - 2) else $error("rc wake");
  a_xtal_wake: assert property ($changed(activeSource) && activeSource inside {[3'h2:3'h4]}
    |-> lowCnt_ff >= XTAL_WAKE - 2) else $error("xtal wake");
  a_div_run: assert property (wbAck && wbWe && wbAdr == OFS_DIV && lowCnt_ff < 13'd511
    |-> ##[1:520] processorClockEn) else $error("clock stalled");
endmodule : ccsd_assertions
bind ccsd_top ccsd_assertions u_ccsd_assertions (.*);
`default_nettype wire

/* File: tb/tb_top.sv */
/* Bench for ccsd_top.
   Assumes the checker is bound. */
`timescale 1ns/1ps
`default_nettype none
module tb_top import ccsd_pkg::*;;
  logic        clock, rstn, wbCyc, wbStb, wbWe, wbAck, processorClockEn, lowPowerClocking;
  logic [3:0]  wbAdr, wbSel;
  logic [31:0] wbDatI, wbDatO, q;
  logic [2:0]  activeSource;
  logic [31:0] rng = 32'h0000284b;
  logic [2:0]  srcs [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h1};
  int          n_fail, n_checks, cyc, t, w;
  ccsd_top u_ccsd_top (
    .clock            (clock),
    .rstn             (rstn),
    .wbCyc            (wbCyc),
    .wbStb            (wbStb),
    .wbWe             (wbWe),
    .wbAdr            (wbAdr),
    .wbSel            (wbSel),
    .wbDatI           (wbDatI),
    .wbDatO           (wbDatO),
    .wbAck            (wbAck),
    .processorClockEn (processorClockEn),
    .activeSource     (activeSource),
    .lowPowerClocking (lowPowerClocking)
  );
  initial begin
    clock = 0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      results();
    end
  end
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs
  // Wake-up bounds in cycles from the stated times; the bench clock stands in for the oscillator
  function automatic int wake(int s, bit hi);
    int us = CLK_HZ / 1_000_000;
    if (s == 0 || s == 5) return 32;
    if (s == 1) return (hi ? 300 : 200) * us;
    return 1024 + (hi ? 100 : 60) * us;
  endfunction : wake
  task automatic chk(logic [31:0] s, logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // Request stands until the rising edge at which ack is sampled high; data is taken there
  task automatic wb(logic wr, logic [3:0] a, logic [31:0] d);
    @(posedge clock);
    {wbCyc, wbStb, wbWe, wbAdr, wbDatI} <= {2'b11, wr, a, d};
    do @(posedge clock); while (wbAck !== 1'b1);
    q = wbDatO;
    {wbCyc, wbStb} <= 2'b00;
  endtask : wb
  task automatic per(output int p);
    p = 0;
    do @(negedge clock); while (processorClockEn !== 1'b1);
    do begin
      @(negedge clock);
      p++;
    end while (processorClockEn !== 1'b1);
  endtask : per
  task automatic rst();
    rstn <= 0;
    repeat (10) @(posedge clock);
    rstn <= 1;
    do wb(0, OFS_CLKSRC, 0); while (q[SWDONE_BIT] !== 1'b1);
    wb(0, OFS_AUX1, 0);
    chk(q[LOWPWR_BIT], 0);
    chk(lowPowerClocking, 0);
  endtask : rst
  task automatic results();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial begin
    {rstn, wbCyc, wbStb, wbWe, wbAdr, wbDatI, cyc, n_fail, n_checks} = '0;
    wbSel = 4'h1;
    rst();
    chk(activeSource, SRC_RESET);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      w = (i == 0) ? 0 : (i == 1) ? 255 : xs() % 255 + 1;
      wb(1, OFS_DIV, w);
      per(t);
      per(t);
      chk(t, w ? 2 * w : 1);
      wb(0, OFS_DIV, 0);
      chk(q, w);
    end
    $display("divider test done");
    foreach (srcs[i]) begin
      wb(1, OFS_CLKSRC, srcs[i]);
      t = cyc;
      wb(0, OFS_CLKSRC, 0);
      chk(q[SWDONE_BIT], 0);
      wb(0, OFS_STATUS, 0);
      chk(q[RUN_BIT], 0);
      wb(1, OFS_CLKSRC, srcs[i] ^ 3'h1);
      do @(negedge clock); while (activeSource !== srcs[i]);
      chk(cyc - t >= wake(srcs[i], 0) && cyc - t <= wake(srcs[i], 1) + 4, 1);
      wb(0, OFS_CLKSRC, 0);
      chk({q[SWDONE_BIT], q[2:0]}, {1'b1, srcs[i]});
      wb(0, OFS_STATUS, 0);
      chk(q[RUN_BIT], 1);
    end
    wb(1, OFS_CLKSRC, 7);
    wb(0, OFS_CLKSRC, 0);
    chk({q[SWDONE_BIT], q[2:0]}, 4'h9);
    wb(0, 4'h2, 0);
    chk(q, 0);
    $display("switch test done");
    // Slow the processor clock to 5 MHz before asking for low-power clocking
    wb(1, OFS_DIV, 2);
    wb(1, OFS_AUX1, 32'h80);
    wb(0, OFS_AUX1, 0);
    chk(q[LOWPWR_BIT], 1);
    chk(lowPowerClocking, 1);
    rst();
    $display("low power test done");
    results();
  end
endmodule : tb_top
`default_nettype wire
